//--- hdl/mmd_pkg.sv
package mmd_pkg;

   // ----------------------------------------------------------------
   // Register bus offsets and reset values
   // ----------------------------------------------------------------
   localparam logic [31:0] MEM_SIZE_OFFSET    = 32'h0000_0000;
   localparam logic [31:0] XRAM_SIZE_OFFSET   = 32'h0000_0004;
   localparam logic [31:0] STATUS_OFFSET      = 32'h0000_0008;
   localparam logic [31:0] BLOCK_OFFSET       = 32'h0000_000c;
   localparam logic [7:0]  MEM_SIZE_RESET     = 8'hcf;
   localparam logic [7:0]  XRAM_SIZE_RESET    = 8'h0c;

   // ----------------------------------------------------------------
   // Memory size encodings
   // ----------------------------------------------------------------
   localparam logic [7:0]  MEM_SIZE_16K       = 8'h04;
   localparam logic [7:0]  MEM_SIZE_32K       = 8'hc8;
   localparam logic [7:0]  MEM_SIZE_48K       = 8'hcc;
   localparam logic [7:0]  MEM_SIZE_60K       = 8'hcf;
   localparam logic [7:0]  XRAM_SIZE_1K       = 8'h0a;

   // ----------------------------------------------------------------
   // Address map
   // ----------------------------------------------------------------
   localparam logic [5:0]  LAST_BLOCK_60K     = 6'h3b;
   localparam logic [5:0]  LAST_BLOCK_48K     = 6'h2f;
   localparam logic [5:0]  LAST_BLOCK_32K     = 6'h1f;
   localparam logic [5:0]  LAST_BLOCK_16K     = 6'h0f;
   localparam logic [15:0] FLASH_TOP_60K      = 16'hefff;
   localparam logic [15:0] VECTOR_LAST        = 16'h003f;
   localparam logic [15:0] RESET_VECTOR       = 16'h0000;
   localparam logic [15:0] LOW_VOLT_VECTOR    = 16'h0004;
   localparam logic [15:0] BREAK_VECTOR       = 16'h003e;
   localparam logic [15:0] OPTION_FIRST       = 16'h0080;
   localparam logic [15:0] OPTION_LAST        = 16'h0084;
   localparam logic [15:0] SECURITY_FIRST     = 16'h0085;
   localparam logic [15:0] SECURITY_LAST      = 16'h008e;
   localparam logic [15:0] SWAP_DISTANCE      = 16'h1000;
   localparam logic [15:0] SFR_FIRST          = 16'hff00;
   localparam logic [15:0] HSRAM_FIRST_768    = 16'hfc00;
   localparam logic [15:0] HSRAM_FIRST_1K     = 16'hfb00;
   localparam logic [15:0] HSRAM_LAST         = 16'hfeff;
   localparam logic [15:0] XRAM_FIRST         = 16'hf400;
   localparam logic [15:0] XRAM_LAST          = 16'hf7ff;
   localparam logic [15:0] XSFR_FIRST         = 16'h0080;
   localparam logic [15:0] XSFR_LAST          = 16'h01d8;

   // ----------------------------------------------------------------
   // Types
   // ----------------------------------------------------------------
   typedef enum logic [2:0] {
      MMD_REGION_NONE,
      MMD_REGION_FLASH,
      MMD_REGION_HSRAM,
      MMD_REGION_XRAM,
      MMD_REGION_SFR,
      MMD_REGION_XSFR
   } mmd_region_type;

   typedef struct packed {
      logic        valid;
      logic        fetch;
      logic        write;
      logic        ext;
      logic [15:0] addr;
      logic [7:0]  wdata;
   } mmd_req_type;

   typedef struct packed {
      logic           valid;
      mmd_region_type region;
      logic           write;
      logic [15:0]    addr;
      logic [7:0]     wdata;
      logic [5:0]     block;
      logic           vector;
      logic           option;
      logic           security;
      logic           swap_copy;
   } mmd_sel_type;

endpackage : mmd_pkg

//--- hdl/mmd_decoder.sv
// Decided for this implementation: the placing of the registers and the AXI4-Lite slave port.
`timescale 1ns/10ps
`default_nettype none
// Operation
// - One flat 16-bit space, 64 KB, for program fetches and data.
// - After reset memory size holds CFH, expansion RAM size 0CH.
// - Expansion RAM size exists only with expansion RAM; 0AH enables 1 KB.
// - Flash blocks are 1 KB; address bits 15..10 give block number.
// - Largest variant: blocks 00H to 3BH; higher addresses are not flash.
// - Largest variant: flash spans 0000H to EFFFH, fetched by PC.
// - 0000H to 003FH is the vector table of start addresses.
// - Vector low byte at even address, high byte at next odd one.
// - Pin, power-on, low-voltage and watchdog resets use vector 0000H.
// - Each source has own even vector; low-voltage 0004H, break 003EH.
// - Option bytes 0080H-0084H, boot-swap copy at 1080H-1084H.
// - Security ID 0085H-008EH, boot-swap copy at 1085H-108EH.
// - Extended SFR accesses take their own interface, not the data path.
// - Ordinary SFRs decode in FF00H to FFFFH.
module mmd_decoder #(
   parameter bit HAS_XRAM = 1'b1
) (
   input  wire logic                  i_clk,
   input  wire logic                  i_resetn,
   // AXI4-Lite slave
   input  wire logic                  i_awvalid,
   output logic                       o_awready,
   input  wire logic [31:0]           i_awaddr,
   input  wire logic                  i_wvalid,
   output logic                       o_wready,
   input  wire logic [31:0]           i_wdata,
   input  wire logic [3:0]            i_wstrb,
   output logic                       o_bvalid,
   input  wire logic                  i_bready,
   output logic [1:0]                 o_bresp,
   input  wire logic                  i_arvalid,
   output logic                       o_arready,
   input  wire logic [31:0]           i_araddr,
   output logic                       o_rvalid,
   input  wire logic                  i_rready,
   output logic [31:0]                o_rdata,
   output logic [1:0]                 o_rresp,
   // Core side
   input  wire mmd_pkg::mmd_req_type  i_req,
   input  wire logic [3:0]            i_reset_src,
   input  wire logic                  i_vec_req,
   input  wire logic [4:0]            i_vec_index,
   input  wire logic                  i_boot_swap,
   output mmd_pkg::mmd_sel_type       o_mem_sel,
   output mmd_pkg::mmd_sel_type       o_xsfr_sel,
   output logic                       o_vec_valid,
   output logic [15:0]                o_vec_addr_lo,
   output logic [15:0]                o_vec_addr_hi
);

   // ----------------------------------------------------------------
   // Reset release
   // ----------------------------------------------------------------
   logic rst_meta_reg;
   logic rst_n_reg;

   always_ff @(posedge i_clk or negedge i_resetn)
   begin
      if (!i_resetn)
      begin
         rst_meta_reg <= 1'b0;
         rst_n_reg    <= 1'b0;
      end
      else
      begin
         rst_meta_reg <= 1'b1;
         rst_n_reg    <= rst_meta_reg;
      end
   end

   // ----------------------------------------------------------------
   // Decode helpers
   // ----------------------------------------------------------------
   function automatic logic [5:0] last_block(input logic [7:0] size);
      case (size)
         mmd_pkg::MEM_SIZE_16K: last_block = mmd_pkg::LAST_BLOCK_16K;
         mmd_pkg::MEM_SIZE_32K: last_block = mmd_pkg::LAST_BLOCK_32K;
         mmd_pkg::MEM_SIZE_48K: last_block = mmd_pkg::LAST_BLOCK_48K;
         default:               last_block = mmd_pkg::LAST_BLOCK_60K;
      endcase
   endfunction : last_block

   function automatic logic in_range(input logic [15:0] a,
                                     input logic [15:0] lo,
                                     input logic [15:0] hi);
      in_range = (a >= lo) && (a <= hi);
   endfunction : in_range

   // ----------------------------------------------------------------
   // Size registers over AXI4-Lite
   // ----------------------------------------------------------------
   logic [7:0]  mem_size_reg;
   logic [7:0]  xram_size_reg;
   logic        aw_held_reg;
   logic [31:0] aw_addr_reg;
   logic        w_held_reg;
   logic [31:0] w_data_reg;
   logic [3:0]  w_strb_reg;
   logic [1:0]  miss_reg;
   logic [15:0] miss_addr_reg;

   wire logic do_write = aw_held_reg && w_held_reg && !o_bvalid;

   always_ff @(posedge i_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         aw_held_reg <= 1'b0;
         aw_addr_reg <= 32'h0000_0000;
         w_held_reg  <= 1'b0;
         w_data_reg  <= 32'h0000_0000;
         w_strb_reg  <= 4'h0;
      end
      else
      begin
         if (i_awvalid && o_awready)
         begin
            aw_held_reg <= 1'b1;
            aw_addr_reg <= i_awaddr;
         end
         else if (do_write)
            aw_held_reg <= 1'b0;
         if (i_wvalid && o_wready)
         begin
            w_held_reg <= 1'b1;
            w_data_reg <= i_wdata;
            w_strb_reg <= i_wstrb;
         end
         else if (do_write)
            w_held_reg <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         o_awready <= 1'b1;
         o_wready  <= 1'b1;
      end
      else
      begin
         o_awready <= !(aw_held_reg || (i_awvalid && o_awready)) ||
                      do_write;
         o_wready  <= !(w_held_reg || (i_wvalid && o_wready)) || do_write;
         if (i_awvalid && o_awready)
            o_awready <= 1'b0;
         if (i_wvalid && o_wready)
            o_wready <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         mem_size_reg  <= mmd_pkg::MEM_SIZE_RESET;
         xram_size_reg <= mmd_pkg::XRAM_SIZE_RESET;
         o_bvalid      <= 1'b0;
         o_bresp       <= 2'b00;
      end
      else
      begin
         if (do_write)
         begin
            o_bvalid <= 1'b1;
            o_bresp  <= 2'b00;
            case (aw_addr_reg[7:0])
               mmd_pkg::MEM_SIZE_OFFSET[7:0]:
                  if (w_strb_reg[0])
                     mem_size_reg <= w_data_reg[7:0];
               mmd_pkg::XRAM_SIZE_OFFSET[7:0]:
                  if (HAS_XRAM && w_strb_reg[0])
                     xram_size_reg <= w_data_reg[7:0];
                  else if (!HAS_XRAM)
                     o_bresp <= 2'b10;
               mmd_pkg::STATUS_OFFSET[7:0],
               mmd_pkg::BLOCK_OFFSET[7:0]: o_bresp <= 2'b00;
               default: o_bresp <= 2'b10;
            endcase
            if (aw_addr_reg[31:8] != 24'h00_0000)
               o_bresp <= 2'b10;
         end
         else if (o_bvalid && i_bready)
            o_bvalid <= 1'b0;
      end
   end

   always_ff @(posedge i_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         o_arready <= 1'b1;
         o_rvalid  <= 1'b0;
         o_rdata   <= 32'h0000_0000;
         o_rresp   <= 2'b00;
      end
      else if (i_arvalid && o_arready)
      begin
         o_arready <= 1'b0;
         o_rvalid  <= 1'b1;
         o_rresp   <= 2'b00;
         o_rdata   <= 32'h0000_0000;
         if (i_araddr[31:8] != 24'h00_0000)
            o_rresp <= 2'b10;
         else
            case (i_araddr[7:0])
               mmd_pkg::MEM_SIZE_OFFSET[7:0]:
                  o_rdata <= {24'h00_0000, mem_size_reg};
               mmd_pkg::XRAM_SIZE_OFFSET[7:0]:
                  if (HAS_XRAM)
                     o_rdata <= {24'h00_0000, xram_size_reg};
                  else
                     o_rresp <= 2'b10;
               mmd_pkg::STATUS_OFFSET[7:0]:
                  o_rdata <= {14'h0, miss_reg, miss_addr_reg};
               mmd_pkg::BLOCK_OFFSET[7:0]:
                  o_rdata <= {26'h0, last_block(mem_size_reg)};
               default: o_rresp <= 2'b10;
            endcase
      end
      else if (o_rvalid && i_rready)
      begin
         o_rvalid  <= 1'b0;
         o_arready <= 1'b1;
      end
   end

   // ----------------------------------------------------------------
   // Address decode
   // ----------------------------------------------------------------
   mmd_pkg::mmd_region_type region;
   logic [15:0]             hsram_first;
   logic                    xram_on;

   always_comb
   begin
      // Dense top page wins so SFRs never alias onto RAM
      hsram_first = (mem_size_reg == mmd_pkg::MEM_SIZE_60K) ?
                    mmd_pkg::HSRAM_FIRST_1K : mmd_pkg::HSRAM_FIRST_768;
      xram_on     = HAS_XRAM && (xram_size_reg == mmd_pkg::XRAM_SIZE_1K);
      region      = mmd_pkg::MMD_REGION_NONE;
      if (i_req.ext)
      begin
         if (!i_req.fetch &&
             in_range(i_req.addr, mmd_pkg::XSFR_FIRST, mmd_pkg::XSFR_LAST))
            region = mmd_pkg::MMD_REGION_XSFR;
      end
      else if (i_req.addr >= mmd_pkg::SFR_FIRST)
      begin
         if (!i_req.fetch)
            region = mmd_pkg::MMD_REGION_SFR;
      end
      else if (in_range(i_req.addr, hsram_first, mmd_pkg::HSRAM_LAST))
      begin
         if (!i_req.fetch)
            region = mmd_pkg::MMD_REGION_HSRAM;
      end
      else if (xram_on &&
               in_range(i_req.addr, mmd_pkg::XRAM_FIRST,
                        mmd_pkg::XRAM_LAST))
         region = mmd_pkg::MMD_REGION_XRAM;
      else if (i_req.addr <= mmd_pkg::FLASH_TOP_60K &&
               i_req.addr[15:10] <= last_block(mem_size_reg))
         if (!i_req.write || !i_req.fetch)
            region = i_req.write ? mmd_pkg::MMD_REGION_NONE
                                 : mmd_pkg::MMD_REGION_FLASH;
   end

   // ----------------------------------------------------------------
   // Registered selects
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         o_mem_sel     <= '0;
         o_xsfr_sel    <= '0;
         miss_reg      <= 2'b00;
         miss_addr_reg <= 16'h0000;
      end
      else
      begin
         o_mem_sel  <= '0;
         o_xsfr_sel <= '0;
         if (i_req.valid)
         begin
            if (region == mmd_pkg::MMD_REGION_XSFR)
            begin
               o_xsfr_sel.valid  <= 1'b1;
               o_xsfr_sel.region <= region;
               o_xsfr_sel.write  <= i_req.write;
               o_xsfr_sel.addr   <= i_req.addr;
               o_xsfr_sel.wdata  <= i_req.wdata;
            end
            else if (region != mmd_pkg::MMD_REGION_NONE)
            begin
               o_mem_sel.valid    <= 1'b1;
               o_mem_sel.region   <= region;
               o_mem_sel.write    <= i_req.write;
               o_mem_sel.addr     <= i_req.addr;
               o_mem_sel.wdata    <= i_req.wdata;
               o_mem_sel.block    <= i_req.addr[15:10];
               o_mem_sel.vector   <= i_req.addr <= mmd_pkg::VECTOR_LAST;
               o_mem_sel.option   <= in_range(i_req.addr,
                  mmd_pkg::OPTION_FIRST, mmd_pkg::OPTION_LAST) ||
                  (i_boot_swap && in_range(i_req.addr,
                     mmd_pkg::OPTION_FIRST + mmd_pkg::SWAP_DISTANCE,
                     mmd_pkg::OPTION_LAST + mmd_pkg::SWAP_DISTANCE));
               o_mem_sel.security <= in_range(i_req.addr,
                  mmd_pkg::SECURITY_FIRST, mmd_pkg::SECURITY_LAST) ||
                  (i_boot_swap && in_range(i_req.addr,
                     mmd_pkg::SECURITY_FIRST + mmd_pkg::SWAP_DISTANCE,
                     mmd_pkg::SECURITY_LAST + mmd_pkg::SWAP_DISTANCE));
               o_mem_sel.swap_copy <= i_boot_swap &&
                  in_range(i_req.addr,
                     mmd_pkg::OPTION_FIRST + mmd_pkg::SWAP_DISTANCE,
                     mmd_pkg::SECURITY_LAST + mmd_pkg::SWAP_DISTANCE);
            end
            else
            begin
               // Sticky record of the last stray access
               miss_reg      <= {i_req.write, 1'b1};
               miss_addr_reg <= i_req.addr;
            end
         end
      end
   end

   // ----------------------------------------------------------------
   // Vector addresses
   // ----------------------------------------------------------------
   always_ff @(posedge i_clk or negedge rst_n_reg)
   begin
      if (!rst_n_reg)
      begin
         o_vec_valid   <= 1'b0;
         o_vec_addr_lo <= 16'h0000;
         o_vec_addr_hi <= 16'h0000;
      end
      else
      begin
         o_vec_valid <= i_vec_req || (i_reset_src != 4'h0);
         if (i_reset_src != 4'h0)
         begin
            o_vec_addr_lo <= mmd_pkg::RESET_VECTOR;
            o_vec_addr_hi <= mmd_pkg::RESET_VECTOR + 16'h0001;
         end
         else if (i_vec_req)
         begin
            o_vec_addr_lo <= {10'h000, i_vec_index, 1'b0};
            o_vec_addr_hi <= {10'h000, i_vec_index, 1'b1};
         end
      end
   end

endmodule : mmd_decoder
`default_nettype wire

//--- verification/mmd_decoder_properties.sv
`timescale 1ns/10ps
`default_nettype none
module mmd_decoder_properties (
   input wire logic                 i_clk,
   input wire logic                 i_resetn,
   input wire mmd_pkg::mmd_req_type i_req,
   input wire logic [3:0]           i_reset_src,
   input wire logic                 i_vec_req,
   input wire logic [4:0]           i_vec_index,
   input wire mmd_pkg::mmd_sel_type o_mem_sel,
   input wire mmd_pkg::mmd_sel_type o_xsfr_sel,
   input wire logic                 o_vec_valid,
   input wire logic [15:0]          o_vec_addr_lo,
   input wire logic [15:0]          o_vec_addr_hi
);
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (!i_resetn);

   // ----------------------------------------------------------------
   // Select and vector checks
   // ----------------------------------------------------------------
   a_sel_addr_echo:
      assert property (o_mem_sel.valid |-> $past(i_req.valid)
         && o_mem_sel.addr == $past(i_req.addr))
      else $error("select address differs");
   a_block_number:
      assert property (o_mem_sel.valid
         |-> o_mem_sel.block == o_mem_sel.addr[15:10])
      else $error("block number wrong");
   a_flash_bound:
      assert property (o_mem_sel.valid
         && o_mem_sel.region == mmd_pkg::MMD_REGION_FLASH
         |-> !o_mem_sel.write && o_mem_sel.addr <= 16'hefff
         && o_mem_sel.block <= 6'h3b)
      else $error("flash select out of bounds");
   a_vector_flag:
      assert property (o_mem_sel.valid
         |-> o_mem_sel.vector == (o_mem_sel.addr <= 16'h003f))
      else $error("vector flag wrong");
   a_option_area:
      assert property (o_mem_sel.valid && !o_mem_sel.swap_copy |->
         o_mem_sel.option == (o_mem_sel.addr inside {[16'h0080:16'h0084]})
         && o_mem_sel.security
         == (o_mem_sel.addr inside {[16'h0085:16'h008e]}))
      else $error("option or security flag wrong");
   a_xsfr_route:
      assert property (o_xsfr_sel.valid |-> $past(i_req.ext)
         && !o_mem_sel.valid
         && o_xsfr_sel.region == mmd_pkg::MMD_REGION_XSFR)
      else $error("extended access misrouted");
   a_sfr_page:
      assert property (o_mem_sel.valid
         && o_mem_sel.region == mmd_pkg::MMD_REGION_SFR
         |-> o_mem_sel.addr[15:8] == 8'hff)
      else $error("register select outside top page");
   a_vec_pair:
      assert property (o_vec_valid |-> !o_vec_addr_lo[0]
         && o_vec_addr_hi == o_vec_addr_lo + 16'h0001)
      else $error("vector byte pair wrong");
   a_vec_index:
      assert property (i_vec_req && i_reset_src == 4'h0 |=> o_vec_valid
         && o_vec_addr_lo == {10'h000, $past(i_vec_index), 1'b0})
      else $error("vector address wrong");
   a_reset_vector:
      assert property (|i_reset_src
         |=> o_vec_valid && o_vec_addr_lo == 16'h0000)
      else $error("reset vector wrong");
endmodule : mmd_decoder_properties

bind mmd_decoder mmd_decoder_properties u_mmd_decoder_properties (
   .i_clk, .i_resetn, .i_req, .i_reset_src, .i_vec_req, .i_vec_index,
   .o_mem_sel, .o_xsfr_sel, .o_vec_valid, .o_vec_addr_lo, .o_vec_addr_hi
);
`default_nettype wire

//--- verification/mmd_core_model.sv
`timescale 1ns/10ps
`default_nettype none
module mmd_core_model (
   input  wire logic                i_clk,
   output var mmd_pkg::mmd_req_type o_req
);
   // ----------------------------------------------------------------
   // Core access driver
   // ----------------------------------------------------------------
   initial o_req = '0;

   // One byte a call, back to back allowed
   task automatic issue(input logic [2:0] fwx, input logic [15:0] a);
      o_req <= {1'b1, fwx, a, 8'h5a};
      @(posedge i_clk);
   endtask : issue

   // Released lines show the inverse, never a stale copy
   task automatic idle;
      o_req <= {1'b0, ~o_req[26:0]};
      @(posedge i_clk);
   endtask : idle
endmodule : mmd_core_model
`default_nettype wire

//--- verification/mmd_decoder_tb.sv
`timescale 1ns/10ps
`default_nettype none
module mmd_decoder_tb;
   logic                 i_clk, i_resetn, i_awvalid, i_wvalid, i_bready;
   logic                 i_arvalid, i_rready, i_vec_req, i_boot_swap;
   logic                 o_awready, o_wready, o_bvalid, o_arready;
   logic                 o_rvalid, o_vec_valid;
   logic [31:0]          i_awaddr, i_wdata, i_araddr, o_rdata;
   logic [1:0]           o_bresp, o_rresp;
   logic [3:0]           i_wstrb, i_reset_src;
   logic [4:0]           i_vec_index;
   logic [15:0]          o_vec_addr_lo, o_vec_addr_hi, a;
   mmd_pkg::mmd_req_type i_req;
   mmd_pkg::mmd_sel_type o_mem_sel, o_xsfr_sel;
   logic [35:0]          exp_q[$];
   int                   mismatches, checks_done, seed;
   localparam logic [2:0] NO = 3'd0, FL = 3'd1, HS = 3'd2, XR = 3'd3;
   localparam logic [2:0] SF = 3'd4, XS = 3'd5;
   logic [7:0]  sz[3]  = '{8'hc8, 8'hcc, 8'hcf};
   logic [15:0] top[3] = '{16'h7fff, 16'hbfff, 16'hefff};

   mmd_decoder u_mmd_decoder (.i_clk, .i_resetn, .i_awvalid, .o_awready,
      .i_awaddr, .i_wvalid, .o_wready, .i_wdata, .i_wstrb, .o_bvalid,
      .i_bready, .o_bresp, .i_arvalid, .o_arready, .i_araddr, .o_rvalid,
      .i_rready, .o_rdata, .o_rresp, .i_req, .i_reset_src, .i_vec_req,
      .i_vec_index, .i_boot_swap, .o_mem_sel, .o_xsfr_sel, .o_vec_valid,
      .o_vec_addr_lo, .o_vec_addr_hi);
   mmd_core_model u_mmd_core_model (.i_clk, .o_req(i_req));

   initial
   begin
      i_clk = 1'b0;
      forever #12.5 i_clk = ~i_clk;
   end

   // ----------------------------------------------------------------
   // Scoreboard
   // ----------------------------------------------------------------
   task automatic conclude;
      $display("mismatches %0d checks %0d", mismatches, checks_done);
      if (mismatches == 0 && checks_done > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask : conclude

   task automatic guard(input int n);
      if (n > 60)
      begin
         mismatches++;
         conclude();
      end
   endtask : guard

   task automatic note(input logic [1:0] k, input logic [33:0] v);
      exp_q.push_back({k, v});
   endtask : note

   task automatic got(input logic [35:0] act);
      logic [35:0] e;
      checks_done++;
      e = (exp_q.size() == 0) ? '1 : exp_q.pop_front();
      if (e !== act)
      begin
         mismatches++;
         $display("[FAIL] %0t exp %h got %h", $time, e, act);
      end
   endtask : got

   function automatic logic [33:0] skey(input mmd_pkg::mmd_sel_type s);
      return {4'h0, s.region, s.vector, s.option, s.security,
              s.swap_copy, s.write, s.block, s.addr};
   endfunction : skey

   always @(posedge i_clk)
   begin
      if (o_mem_sel.valid === 1'b1)
         got({2'd0, skey(o_mem_sel)});
      if (o_xsfr_sel.valid === 1'b1)
         got({2'd1, skey(o_xsfr_sel)});
      if (o_vec_valid === 1'b1)
         got({4'h8, o_vec_addr_hi, o_vec_addr_lo});
      if (o_rvalid === 1'b1 && i_rready === 1'b1)
         got({2'd3, o_rresp, o_rdata});
      if (o_bvalid === 1'b1 && i_bready === 1'b1)
         got({2'd3, o_bresp, 32'hffff_ffff});
   end

   // ----------------------------------------------------------------
   // Drivers
   // ----------------------------------------------------------------
   // Flags: vector, option, security, swap copy, write
   task automatic acc(input logic [2:0] fwx, input logic [15:0] ad,
                      input logic [2:0] r, input logic [4:0] f);
      if (r != NO)
         note({1'b0, fwx[0]}, {4'h0, r, f, ad[15:10], ad});
      u_mmd_core_model.issue(fwx, ad);
   endtask : acc

   task automatic wr(input logic [31:0] ad, input logic [31:0] d);
      int  n;
      logic aw, w;
      note(2'd3, {2'b00, 32'hffff_ffff});
      {i_awvalid, i_wvalid, i_bready} <= 3'b111;
      i_awaddr <= ad;
      i_wdata  <= d;
      {aw, w, n} = {2'b11, 32'd0};
      do
      begin
         @(posedge i_clk);
         guard(n++);
         if (aw && o_awready === 1'b1)
         begin
            aw = 1'b0;
            i_awvalid <= 1'b0;
         end
         if (w && o_wready === 1'b1)
         begin
            w = 1'b0;
            i_wvalid <= 1'b0;
         end
      end
      while (aw || w);
      while (o_bvalid !== 1'b1)
      begin
         @(posedge i_clk);
         guard(n++);
      end
      i_bready <= 1'b0;
   endtask : wr

   task automatic rd(input logic [31:0] ad, input logic [33:0] v);
      int n;
      note(2'd3, v);
      {i_arvalid, i_rready} <= 2'b11;
      i_araddr <= ad;
      n = 0;
      do
      begin
         @(posedge i_clk);
         guard(n++);
      end
      while (o_arready !== 1'b1);
      i_arvalid <= 1'b0;
      do
      begin
         @(posedge i_clk);
         guard(n++);
      end
      while (o_rvalid !== 1'b1);
   endtask : rd

   initial
   begin
      {seed, mismatches, checks_done} = {32'd3, 64'd0};
      {i_resetn, i_awvalid, i_wvalid, i_bready, i_arvalid} = 5'h0;
      {i_rready, i_vec_req, i_boot_swap, i_reset_src} = 7'h0;
      {i_awaddr, i_wdata, i_araddr, i_vec_index} = '0;
      i_wstrb = 4'h1;
      repeat (10) @(posedge i_clk);
      i_resetn <= 1'b1;
      repeat (3) @(posedge i_clk);
      rd(32'h0, {2'b00, 32'hcf});
      rd(32'h4, {2'b00, 32'h0c});
      $display("reset values done");
      foreach (sz[i])
      begin
         wr(32'h0, {24'h0, sz[i]});
         rd(32'h0, {10'h0, sz[i]});
         acc(3'b100, top[i], FL, 5'h00);
         acc(3'b000, top[i] + 16'h1, NO, 5'h00);
         u_mmd_core_model.idle();
      end
      rd(32'h8, {2'b00, 32'h0001_f000});
      $display("flash sizes done");
      acc(3'b000, 16'h0004, FL, 5'h10);
      acc(3'b000, 16'h003f, FL, 5'h10);
      acc(3'b000, 16'h0040, FL, 5'h00);
      acc(3'b000, 16'h0084, FL, 5'h08);
      acc(3'b000, 16'h0085, FL, 5'h04);
      acc(3'b000, 16'h1082, FL, 5'h00);
      acc(3'b010, 16'h0100, NO, 5'h00);
      acc(3'b010, 16'hff10, SF, 5'h01);
      acc(3'b100, 16'hff10, NO, 5'h00);
      acc(3'b001, 16'h0100, XS, 5'h00);
      acc(3'b000, 16'hfb00, HS, 5'h00);
      acc(3'b000, 16'hf500, NO, 5'h00);
      i_boot_swap <= 1'b1;
      acc(3'b000, 16'h1080, FL, 5'h0a);
      acc(3'b000, 16'h108e, FL, 5'h06);
      u_mmd_core_model.idle();
      wr(32'h4, 32'h0a);
      acc(3'b000, 16'hf500, XR, 5'h00);
      $display("address map done");
      i_boot_swap <= 1'b0;
      for (int k = 0; k < 24; k++)
      begin
         a = 16'($random(seed)) % 16'hf000;
         acc(3'b000, a, FL, {a <= 16'h003f, a inside {[16'h80:16'h84]},
             a inside {[16'h85:16'h8e]}, 2'b00});
      end
      u_mmd_core_model.idle();
      $display("random flash done");
      for (int k = 0; k < 36; k++)
      begin
         i_vec_req   <= 1'b1;
         i_vec_index <= 5'(k);
         i_reset_src <= (k < 32) ? 4'h0 : 4'h1 << (k - 32);
         if (k < 32)
            note(2'd2, {12'h000, 5'(k), 1'b1, 10'h000, 5'(k), 1'b0});
         else
            note(2'd2, {2'b00, 16'h0001, 16'h0000});
         @(posedge i_clk);
      end
      {i_vec_req, i_reset_src} <= 5'h0;
      $display("vectors done");
      for (int n = 0; exp_q.size() != 0; n++)
      begin
         @(posedge i_clk);
         guard(n);
      end
      conclude();
   end
endmodule : mmd_decoder_tb
`default_nettype wire
